// File: design/adc_event_consts.vh
`ifndef ADC_EVENT_CONSTS_VH
`define ADC_EVENT_CONSTS_VH
// Register byte offsets.
`define OFF_STARTED 12'h100
`define OFF_END 12'h104
`define OFF_DONE 12'h108
`define OFF_RESULT_READY 12'h10c
`define OFF_CAL_COMPLETE 12'h110
`define OFF_STOPPED 12'h114
`define OFF_HIGH_HIT_BASE 12'h118
`define OFF_LOW_HIT_BASE 12'h11c
`define OFF_CHAN_STRIDE 12'h008
`define OFF_IRQ_ENABLE_MASK 12'h300
`define OFF_LIMIT_BASE 12'h400
`define OFF_RESULT 12'h440
// Interrupt enable field positions.
`define IEN_STARTED 0
`define IEN_END 1
`define IEN_DONE 2
`define IEN_RESULT_READY 3
`define IEN_CAL_COMPLETE 4
`define IEN_STOPPED 5
`define IEN_CHAN_BASE 6
`define IEN_WIDTH 22
// Limit register layout: low bound in bits 15:0, high bound in bits 31:16.
`define LIMIT_LOW_LSB 0
`define LIMIT_HIGH_LSB 16
// Reset values.
`define RST_IRQ_ENABLE_MASK 22'h000000
`define RST_LIMIT_WORD 32'h7fff8000
// AXI response codes.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: design/limit_compare.v
`timescale 1ns/1ns
`default_nettype none
// Signed bound comparison for one channel; flags are pulses on a new result.
module limit_compare #(
	parameter RES_W = 16
) (
	// Result strobe.
	input wire result_valid,
	input wire [RES_W-1:0] result,
	// Programmed bounds.
	input wire [RES_W-1:0] low_bound,
	input wire [RES_W-1:0] high_bound,
	// Hit pulses.
	output wire high_bound_hit,
	output wire low_bound_hit
);
	// Results are two's complement, so compare signed.
	assign low_bound_hit = result_valid & ($signed(result) <= $signed(low_bound));
	assign high_bound_hit = result_valid & ($signed(result) >= $signed(high_bound));
endmodule // limit_compare
`default_nettype wire

// File: design/event_flag.v
`timescale 1ns/1ns
`default_nettype none
// Sticky event flag; hardware set wins over a software clear in the same cycle.
module event_flag (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// Set and software write.
	input wire set_pulse,
	input wire wr_en,
	input wire wr_val,
	// Flag.
	output reg flag_q
);
	// Software may write either value; a coincident set keeps the event.
	always @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
		end else if (set_pulse) begin
			flag_q <= 1'b1;
		end else if (wr_en) begin
			flag_q <= wr_val;
		end
	end
endmodule // event_flag
`default_nettype wire

// File: design/adc_limit_event_irq.v
`timescale 1ns/1ns
`default_nettype none
`include "adc_event_consts.vh"
module adc_limit_event_irq #(
	parameter NCH = 8,
	parameter RES_W = 16
) (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address.
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data.
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response.
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address.
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data.
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Event pulses from the converter core.
	input wire started_pulse,
	input wire end_pulse,
	input wire done_pulse,
	input wire result_ready_pulse,
	input wire calibration_complete_pulse,
	input wire stopped_pulse,
	// Latest conversion result.
	input wire result_valid,
	input wire [RES_W-1:0] result,
	// Interrupt request to the processor.
	output reg irq_q
);
	// Flag count: six converter events, then a high and a low flag per channel.
	localparam NFLAG = 6 + 2 * NCH;
	// Fixed converter events ahead of the channel pairs.
	localparam NFIXED = 6;

	// Write path holding registers.
	reg [31:0] awaddr_q;
	reg aw_held_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg w_held_q;

	// Programmable state and the last result.
	reg [NFLAG-1:0] irq_enable_mask_q;
	reg [31:0] limit_q [0:NCH-1];
	reg [RES_W-1:0] result_q;

	// Event flags, their set pulses and the events that are both raised and enabled.
	wire [NFLAG-1:0] flags;
	wire [NFLAG-1:0] set_vec;
	wire [NFLAG-1:0] pending;

	// Write and read decode.
	wire [NFLAG-1:0] wr_sel;
	wire wr_fire;
	wire [11:0] wr_off;
	wire [11:0] rd_off;
	reg rd_hit;
	reg [31:0] rd_word;
	reg wr_hit;

	// Loop indices, one per process so that no variable has two drivers.
	integer i;
	integer j;
	integer k;

	// Address and data are latched separately so they may arrive in any order.
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_off = awaddr_q[11:0];
	assign rd_off = s_axi_araddr;

	// Write address capture; the address is held until the write is performed.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 32'h00000000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			awaddr_q <= {20'h00000, s_axi_awaddr};
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	// Write data capture; it may arrive before or after its address.
	always @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	// Event set vector: fixed events then channel pairs, high first then low.
	assign set_vec[`IEN_STARTED] = started_pulse;
	assign set_vec[`IEN_END] = end_pulse;
	assign set_vec[`IEN_DONE] = done_pulse;
	assign set_vec[`IEN_RESULT_READY] = result_ready_pulse;
	assign set_vec[`IEN_CAL_COMPLETE] = calibration_complete_pulse;
	assign set_vec[`IEN_STOPPED] = stopped_pulse;

	// Flag write selects: fixed events at consecutive words, channels by stride.
	assign wr_sel[0] = wr_off == `OFF_STARTED;
	assign wr_sel[1] = wr_off == `OFF_END;
	assign wr_sel[2] = wr_off == `OFF_DONE;
	assign wr_sel[3] = wr_off == `OFF_RESULT_READY;
	assign wr_sel[4] = wr_off == `OFF_CAL_COMPLETE;
	assign wr_sel[5] = wr_off == `OFF_STOPPED;

	// Per-channel comparators and write selects, then one sticky flag per event.
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : chan
			// Compare against the bound halves of this channel's limit word.
			limit_compare #(
				.RES_W(RES_W)
			) u_cmp (
				.result_valid(result_valid),
				.result(result),
				.low_bound(limit_q[g][`LIMIT_LOW_LSB +: RES_W]),
				.high_bound(limit_q[g][`LIMIT_HIGH_LSB +: RES_W]),
				.high_bound_hit(set_vec[`IEN_CHAN_BASE + 2 * g]),
				.low_bound_hit(set_vec[`IEN_CHAN_BASE + 2 * g + 1])
			);
			assign wr_sel[`IEN_CHAN_BASE + 2 * g] =
				wr_off == `OFF_HIGH_HIT_BASE + g * `OFF_CHAN_STRIDE;
			assign wr_sel[`IEN_CHAN_BASE + 2 * g + 1] =
				wr_off == `OFF_LOW_HIT_BASE + g * `OFF_CHAN_STRIDE;
		end

		for (g = 0; g < NFLAG; g = g + 1) begin : flg
			// Each event is a sticky flag, set by hardware, cleared by software.
			event_flag u_flag (
				.aclk(aclk),
				.aresetn(aresetn),
				.set_pulse(set_vec[g]),
				.wr_en(wr_fire && wr_sel[g] && wstrb_q[0]),
				.wr_val(wdata_q[0]),
				.flag_q(flags[g])
			);
		end
	endgenerate

	// Last result, kept so that software can read back what the bounds were held against.
	always @(posedge aclk) begin
		if (!aresetn) begin
			result_q <= {RES_W{1'b0}};
		end else if (result_valid) begin
			result_q <= result;
		end
	end

	// Register writes: enable mask and channel limits.
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable_mask_q <= `RST_IRQ_ENABLE_MASK;
			for (i = 0; i < NCH; i = i + 1) begin
				limit_q[i] <= `RST_LIMIT_WORD;
			end
		end else begin
			if (wr_fire && wr_off == `OFF_IRQ_ENABLE_MASK) begin
				// Byte lanes apply; 1 enables an event, 0 disables it.
				if (wstrb_q[0]) begin
					irq_enable_mask_q[7:0] <= wdata_q[7:0];
				end
				if (wstrb_q[1]) begin
					irq_enable_mask_q[15:8] <= wdata_q[15:8];
				end
				if (wstrb_q[2]) begin
					irq_enable_mask_q[NFLAG-1:16] <= wdata_q[NFLAG-1:16];
				end
			end
			for (i = 0; i < NCH; i = i + 1) begin
				if (wr_fire && wr_off == `OFF_LIMIT_BASE + i * 4) begin
					if (wstrb_q[0]) begin
						limit_q[i][7:0] <= wdata_q[7:0];
					end
					if (wstrb_q[1]) begin
						limit_q[i][15:8] <= wdata_q[15:8];
					end
					if (wstrb_q[2]) begin
						limit_q[i][23:16] <= wdata_q[23:16];
					end
					if (wstrb_q[3]) begin
						limit_q[i][31:24] <= wdata_q[31:24];
					end
				end
			end
		end
	end

	// Decode whether the pending write lands on a mapped register.
	always @* begin
		wr_hit = (|wr_sel) || wr_off == `OFF_IRQ_ENABLE_MASK;
		for (j = 0; j < NCH; j = j + 1) begin
			if (wr_off == `OFF_LIMIT_BASE + j * 4) begin
				wr_hit = 1'b1;
			end
		end
	end

	// Write response; unmapped addresses get SLVERR and change nothing.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux; flags read in bit 0, enable mask upper bits read zero.
	always @* begin
		rd_hit = 1'b0;
		rd_word = 32'h00000000;
		for (k = 0; k < NFIXED; k = k + 1) begin
			if (rd_off == `OFF_STARTED + k * 4) begin
				rd_hit = 1'b1;
				rd_word = {31'h0, flags[k]};
			end
		end
		for (k = 0; k < NCH; k = k + 1) begin
			if (rd_off == `OFF_HIGH_HIT_BASE + k * `OFF_CHAN_STRIDE) begin
				rd_hit = 1'b1;
				rd_word = {31'h0, flags[`IEN_CHAN_BASE + 2 * k]};
			end
			if (rd_off == `OFF_LOW_HIT_BASE + k * `OFF_CHAN_STRIDE) begin
				rd_hit = 1'b1;
				rd_word = {31'h0, flags[`IEN_CHAN_BASE + 2 * k + 1]};
			end
			if (rd_off == `OFF_LIMIT_BASE + k * 4) begin
				rd_hit = 1'b1;
				rd_word = limit_q[k];
			end
		end
		if (rd_off == `OFF_IRQ_ENABLE_MASK) begin
			rd_hit = 1'b1;
			rd_word = {{(32 - NFLAG){1'b0}}, irq_enable_mask_q};
		end
		if (rd_off == `OFF_RESULT) begin
			rd_hit = 1'b1;
			rd_word = {{(32 - RES_W){1'b0}}, result_q};
		end
	end

	// Read response registered one cycle after the address is taken.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Events that are raised and enabled; a disabled event stays visible in its flag.
	assign pending = flags & irq_enable_mask_q;

	// Level interrupt: any pending event holds the request; registered to avoid glitches.
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |pending;
		end
	end
endmodule // adc_limit_event_irq
`default_nettype wire

// File: tb/adc_limit_event_irq_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Handshake and request-line checks seen from the block's ports only.
module adc_limit_event_irq_sva (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Request line.
	input wire logic irq_q
);
	// One domain, so clock and reset are given once.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A write is both items taken on one edge, answered one or two edges on.
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answered;
		##[1:2] s_axi_bvalid;
	endsequence
	a_reset_quiet: assert property (
		$rose(aresetn) |-> !irq_q && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not quiet after reset");
	a_irq_clear_cause: assert property (
		$fell(irq_q) |-> $past(s_axi_bvalid))
		else $error("request dropped without a register write");
	a_write_answer: assert property (wr_taken |-> wr_answered)
		else $error("write not answered");
	a_bvalid_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response withdrawn");
	a_aw_blocked: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered in one cycle");
	a_read_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule // adc_limit_event_irq_sva
bind adc_limit_event_irq adc_limit_event_irq_sva adc_limit_event_irq_sva_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .irq_q(irq_q));
`default_nettype wire

// File: tb/irq_sink.sv
`timescale 1ns/1ns
`default_nettype none
// Processor-side interrupt input: counts each new request.
module irq_sink (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Request line and its rise count.
	input wire logic irq_q,
	output var logic [7:0] irq_count_q
);
	logic irq_prev_q;
	// Counts on edges, because the controller acts once per new request, not per cycle.
	always_ff @(posedge aclk) begin
		irq_prev_q <= aresetn & irq_q;
		if (!aresetn)
			irq_count_q <= 8'h00;
		else if (irq_q && !irq_prev_q)
			irq_count_q <= irq_count_q + 8'h01;
	end
endmodule // irq_sink
`default_nettype wire

// File: tb/adc_limit_event_irq_enable_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_limit_event_irq_enable_tb;
	// Drivers, answers and counters.
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, result_valid = 0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, rd;
	logic [1:0] bresp_seen = 2'b00;
	logic [15:0] result = 16'h0000;
	logic [5:0] ev = 6'h00;
	logic [3:0] i;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_q;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [7:0] irq_count_q;
	int failures = 0, total_checks = 0;
	always #25 aclk = ~aclk;
	adc_limit_event_irq adc_limit_event_irq_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .started_pulse(ev[0]),
		.end_pulse(ev[1]), .done_pulse(ev[2]), .result_ready_pulse(ev[3]),
		.calibration_complete_pulse(ev[4]), .stopped_pulse(ev[5]),
		.result_valid(result_valid), .result(result), .irq_q(irq_q));
	irq_sink irq_sink_inst (.aclk(aclk), .aresetn(aresetn), .irq_q(irq_q),
		.irq_count_q(irq_count_q));
	task automatic give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Handshakes are judged at mid-cycle, where registered answers have settled and still
	// stand at the next edge; every request and ready is held until its own handshake edge.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		logic aw_go, w_go, b_go;
		n = 0;
		b_go = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_go) begin
			@(negedge aclk);
			aw_go = s_axi_awvalid && s_axi_awready;
			w_go = s_axi_wvalid && s_axi_wready;
			b_go = s_axi_bvalid && s_axi_bready;
			bresp_seen = s_axi_bresp;
			@(posedge aclk);
			if (aw_go) s_axi_awvalid <= 1'b0;
			if (w_go) s_axi_wvalid <= 1'b0;
			n++;
			if (n > 40) begin failures++; give_verdict(); end
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		logic ar_go, r_go;
		logic [1:0] resp;
		n = 0;
		r_go = 1'b0;
		resp = 2'b00;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_go) begin
			@(negedge aclk);
			ar_go = s_axi_arvalid && s_axi_arready;
			r_go = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_go) s_axi_arvalid <= 1'b0;
			n++;
			if (n > 40) begin failures++; give_verdict(); end
		end
		s_axi_rready <= 1'b0;
		chk({30'h0, resp}, {30'h0, er});
		chk(rd, exp);
		@(posedge aclk);
	endtask
	// One-cycle event or result strobe, then one edge for the request to follow.
	task automatic pulse(input logic [5:0] e, input logic rv, input logic [15:0] r);
		@(posedge aclk);
		ev <= e;
		result_valid <= rv;
		result <= r;
		@(posedge aclk);
		ev <= 6'h00;
		result_valid <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic irq_is(input logic exp);
		@(negedge aclk);
		chk({31'h0, irq_q}, {31'h0, exp});
		@(posedge aclk);
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(12'h300, 32'h0, 2'b00);
		rd_chk(12'h11c, 32'h0, 2'b00);
		wr(12'h300, 32'h003fffff);
		chk({30'h0, bresp_seen}, 32'h0);
		rd_chk(12'h300, 32'h003fffff, 2'b00);
		wr(12'h300, 32'h0);
		rd_chk(12'h300, 32'h0, 2'b00);
		rd_chk(12'hffc, 32'h0, 2'b10);
		wr(12'hffc, 32'h0);
		chk({30'h0, bresp_seen}, {30'h0, 2'b10});
		// Each event raises the request only through its own enable bit.
		for (i = 0; i < 6; i++) begin
			wr(12'h300, 32'h1 << i);
			pulse(6'h1 << i, 1'b0, 16'h0000);
			irq_is(1'b1);
			rd_chk(12'h100 + {i, 2'b00}, 32'h1, 2'b00);
			wr(12'h100 + {i, 2'b00}, 32'h0);
			irq_is(1'b0);
		end
		wr(12'h300, 32'h0);
		// Bounds at -256 and 256: one step inside the low bound misses, equality hits.
		for (i = 0; i < 8; i++) begin
			wr(12'h400 + {i, 2'b00}, 32'h0100ff00);
			pulse(6'h00, 1'b1, 16'hff01);
			rd_chk(12'h11c + {i, 3'b000}, 32'h0, 2'b00);
			rd_chk(12'h118 + {i, 3'b000}, 32'h0, 2'b00);
			pulse(6'h00, 1'b1, 16'hff00);
			pulse(6'h00, 1'b1, 16'h0100);
			rd_chk(12'h11c + {i, 3'b000}, 32'h1, 2'b00);
			rd_chk(12'h118 + {i, 3'b000}, 32'h1, 2'b00);
			irq_is(1'b0);
			wr(12'h300, 32'h80 << {i, 1'b0});
			irq_is(1'b1);
			wr(12'h11c + {i, 3'b000}, 32'h0);
			irq_is(1'b0);
			wr(12'h300, 32'h0);
			wr(12'h118 + {i, 3'b000}, 32'h0);
		end
		chk({24'h0, irq_count_q}, 32'd14);
		give_verdict();
	end
endmodule // adc_limit_event_irq_enable_tb
`default_nettype wire
